// ---- logic/dlsr_pkg.sv ----
`default_nettype none
package dlsr_pkg;
    // Register offsets
    localparam logic [7:0] DLSR_OFS_HS_LATCHED  = 8'h3A;
    localparam logic [7:0] DLSR_OFS_THR_LATCHED = 8'h3B;
    localparam logic [7:0] DLSR_OFS_CH2_LIVE    = 8'h41;
    localparam logic [7:0] DLSR_OFS_HS_LIVE     = 8'h42;
    localparam logic [7:0] DLSR_OFS_THR_LIVE    = 8'h43;
    localparam logic [7:0] DLSR_OFS_HIGH_THR    = 8'h4E;
    localparam logic [7:0] DLSR_OFS_LOW_THR     = 8'h4F;
    localparam logic [7:0] DLSR_OFS_DIAG_EN     = 8'h53;
    localparam logic [7:0] DLSR_OFS_FILT_CFG    = 8'h54;

    // Reset values
    localparam logic [7:0] DLSR_RST_LIVE        = 8'h00;
    localparam logic [7:0] DLSR_RST_HIGH_THR    = 8'hBA;
    localparam logic [7:0] DLSR_RST_LOW_THR     = 8'h4B;
    localparam logic [7:0] DLSR_RST_DIAG_EN     = 8'h00;
    localparam logic [7:0] DLSR_RST_FILT_CFG    = 8'h48;
    localparam logic [1:0] DLSR_RST_FILT_SEL    = 2'h2;
    localparam logic [7:0] DLSR_FILT_CFG_FIXED  = 8'h08;
    localparam logic [7:0] DLSR_RD_UNMAPPED     = 8'h00;

    // Field positions
    localparam int DLSR_BIT_CH2_PLUS_SHORT  = 7;
    localparam int DLSR_BIT_CH2_MINUS_SHORT = 6;
    localparam int DLSR_BIT_PLUS_VGND       = 5;
    localparam int DLSR_BIT_MINUS_VGND      = 4;
    localparam int DLSR_BIT_REG_SHORT       = 0;
    localparam int DLSR_BIT_HS_INSERT       = 3;
    localparam int DLSR_BIT_HS_REMOVE       = 2;
    localparam int DLSR_BIT_HS_BUTTON       = 1;
    localparam int DLSR_BIT_AUX_HIGH        = 7;
    localparam int DLSR_BIT_AUX_LOW         = 6;
    localparam int DLSR_BIT_VAD_UP          = 5;
    localparam int DLSR_BIT_VAD_DOWN        = 4;
    localparam int DLSR_BIT_SUPPLY_EN       = 2;
    localparam int DLSR_BIT_AUX_EN          = 1;
    localparam int DLSR_BIT_FILT_LO         = 5;
    localparam int DLSR_BIT_FILT_HI         = 6;
    localparam int DLSR_THR_SHIFT           = 4;

    // Supply-monitor filter choices
    typedef enum logic [1:0] {
        DLSR_FILT_3M5  = 2'h0,
        DLSR_FILT_200K = 2'h1,
        DLSR_FILT_100K = 2'h2,
        DLSR_FILT_NONE = 2'h3
    } dlsr_filt_t;

    // Live conditions from the analog side
    typedef struct packed {
        logic ch2_plus_short;
        logic ch2_minus_short;
        logic plus_vgnd;
        logic minus_vgnd;
        logic reg_short;
        logic hs_insert;
        logic hs_remove;
        logic hs_button;
        logic vad_up;
        logic vad_down;
    } dlsr_live_t;

    // Control port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dlsr_req_t;
endpackage : dlsr_pkg
`default_nettype wire

// ---- logic/dlsr_regs.sv ----
// How it works
// RULE_01: Channel-2 live register bit 7 plus-output short, bit 6 minus-output short.
// RULE_02: Bit 5 plus-driver virtual-ground fault, bit 4 minus-driver virtual-ground fault.
// RULE_03: Bit 0 reads one while analog regulator short is present.
// RULE_04: Channel-2 register shows present state, read-only, resets to zero.
// RULE_05: Headset live register bit 3 insertion, bit 2 removal.
// RULE_06: Headset live register bit 1 reads one during hook or button press.
// RULE_07: Threshold live register bit 7 above high, bit 6 below low threshold.
// RULE_08: Bit 5 voice-activity power-up, bit 4 voice-activity power-down.
// RULE_09: Eight-bit read/write high threshold code, reset 0xBA.
// RULE_10: Eight-bit read/write low threshold code, reset 0x4B.
// RULE_11: Supply diagnostics run only while enable bit 2 is set.
// RULE_12: Aux input diagnostics run only while enable bit 1 is set.
// RULE_13: Filter select bits 6-5: 3.5MHz, 200kHz, 100kHz, none; resets to 2.
// RULE_14: Software writes reserved bits as zero.
// RULE_15: Each live interrupt also latches; latched bit clears once read. Here only headset and threshold bits latch; channel 2 has no latched copy.
// RULE_16: High flag while measurement exceeds high, low flag while below low.
// RULE_17: Writes to live registers ignored; reads return sampled conditions.
`timescale 1ns/1ps
`default_nettype none
module dlsr_regs #(
    parameter int MEAS_W = 12
) (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    // Control port
    input  wire dlsr_pkg::dlsr_req_t  req_i,
    output logic [7:0]                rdata_o,
    output logic                      rvalid_o,
    // Live conditions
    input  wire dlsr_pkg::dlsr_live_t live_i,
    input  wire logic [MEAS_W-1:0]    aux_meas_i,
    input  wire logic                 aux_meas_valid_i,
    // Diagnostics configuration
    output logic                      supply_diag_enable_o,
    output logic                      aux_input_diag_enable_o,
    output dlsr_pkg::dlsr_filt_t      supply_monitor_filter_select_o
);
    import dlsr_pkg::*;

    dlsr_live_t          live_ff;
    logic                aux_high_ff;
    logic                aux_low_ff;
    logic [7:0]          high_thr_ff;
    logic [7:0]          low_thr_ff;
    logic                supply_en_ff;
    logic                aux_en_ff;
    dlsr_filt_t          filt_ff;
    logic [7:0]          hs_ltch_ff;
    logic [7:0]          thr_ltch_ff;
    logic [7:0]          rdata_ff;
    logic                rvalid_ff;
    logic [7:0]          ch2_live;
    logic [7:0]          hs_live;
    logic [7:0]          thr_live;
    logic [7:0]          nxt_rdata;
    logic [MEAS_W-1:0]   high_lvl;
    logic [MEAS_W-1:0]   low_lvl;
    logic                wr_hit;
    logic                rd_hs_ltch;
    logic                rd_thr_ltch;

    assign wr_hit      = req_i.wr;
    assign rd_hs_ltch  = req_i.rd && (req_i.addr == DLSR_OFS_HS_LATCHED);
    assign rd_thr_ltch = req_i.rd && (req_i.addr == DLSR_OFS_THR_LATCHED);
    assign high_lvl    = MEAS_W'({high_thr_ff, 4'h0});
    assign low_lvl     = MEAS_W'({low_thr_ff, 4'h0});

    // Live register images
    always_comb begin
        ch2_live = DLSR_RST_LIVE;
        ch2_live[DLSR_BIT_CH2_PLUS_SHORT]  = live_ff.ch2_plus_short;   // [RULE_01]
        ch2_live[DLSR_BIT_CH2_MINUS_SHORT] = live_ff.ch2_minus_short;  // [RULE_01]
        ch2_live[DLSR_BIT_PLUS_VGND]       = live_ff.plus_vgnd;        // [RULE_02]
        ch2_live[DLSR_BIT_MINUS_VGND]      = live_ff.minus_vgnd;       // [RULE_02]
        ch2_live[DLSR_BIT_REG_SHORT]       = live_ff.reg_short;        // [RULE_03]
        hs_live = DLSR_RST_LIVE;
        hs_live[DLSR_BIT_HS_INSERT]        = live_ff.hs_insert;        // [RULE_05]
        hs_live[DLSR_BIT_HS_REMOVE]        = live_ff.hs_remove;        // [RULE_05]
        hs_live[DLSR_BIT_HS_BUTTON]        = live_ff.hs_button;        // [RULE_06]
        thr_live = DLSR_RST_LIVE;
        thr_live[DLSR_BIT_AUX_HIGH]        = aux_high_ff;              // [RULE_07]
        thr_live[DLSR_BIT_AUX_LOW]         = aux_low_ff;               // [RULE_07]
        thr_live[DLSR_BIT_VAD_UP]          = live_ff.vad_up;           // [RULE_08]
        thr_live[DLSR_BIT_VAD_DOWN]        = live_ff.vad_down;         // [RULE_08]
    end

    // Condition sampling
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            live_ff <= '0;                                             // [RULE_04]
        end else begin
            live_ff <= live_i;                                         // [RULE_04] [RULE_17]
        end
    end

    // Aux input threshold comparison
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            aux_high_ff <= 1'b0;
            aux_low_ff  <= 1'b0;
        end else if (!aux_en_ff) begin
            aux_high_ff <= 1'b0;                                       // [RULE_12]
            aux_low_ff  <= 1'b0;                                       // [RULE_12]
        end else if (aux_meas_valid_i) begin
            aux_high_ff <= aux_meas_i > high_lvl;                      // [RULE_16]
            aux_low_ff  <= aux_meas_i < low_lvl;                       // [RULE_16]
        end
    end

    // Threshold registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            high_thr_ff <= DLSR_RST_HIGH_THR;                          // [RULE_09]
            low_thr_ff  <= DLSR_RST_LOW_THR;                           // [RULE_10]
        end else if (wr_hit) begin
            if (req_i.addr == DLSR_OFS_HIGH_THR) begin
                high_thr_ff <= req_i.wdata;                            // [RULE_09]
            end
            if (req_i.addr == DLSR_OFS_LOW_THR) begin
                low_thr_ff <= req_i.wdata;                             // [RULE_10]
            end
        end
    end

    // Diagnostic enables and filter select
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            supply_en_ff <= DLSR_RST_DIAG_EN[DLSR_BIT_SUPPLY_EN];
            aux_en_ff    <= DLSR_RST_DIAG_EN[DLSR_BIT_AUX_EN];
            filt_ff      <= dlsr_filt_t'(DLSR_RST_FILT_SEL);           // [RULE_13]
        end else if (wr_hit) begin
            if (req_i.addr == DLSR_OFS_DIAG_EN) begin
                supply_en_ff <= req_i.wdata[DLSR_BIT_SUPPLY_EN];       // [RULE_11]
                aux_en_ff    <= req_i.wdata[DLSR_BIT_AUX_EN];          // [RULE_12]
            end
            if (req_i.addr == DLSR_OFS_FILT_CFG) begin
                filt_ff <= dlsr_filt_t'(req_i.wdata[DLSR_BIT_FILT_HI:DLSR_BIT_FILT_LO]); // [RULE_13]
            end
        end
    end

    // Latched copies, a new set wins over the read clear
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hs_ltch_ff  <= DLSR_RST_LIVE;
            thr_ltch_ff <= DLSR_RST_LIVE;
        end else begin
            hs_ltch_ff  <= (rd_hs_ltch ? 8'h00 : hs_ltch_ff) | hs_live;    // [RULE_15]
            thr_ltch_ff <= (rd_thr_ltch ? 8'h00 : thr_ltch_ff) | thr_live; // [RULE_15]
        end
    end

    // Read mux
    always_comb begin
        case (req_i.addr)
            DLSR_OFS_HS_LATCHED:  nxt_rdata = hs_ltch_ff;              // [RULE_15]
            DLSR_OFS_THR_LATCHED: nxt_rdata = thr_ltch_ff;             // [RULE_15]
            DLSR_OFS_CH2_LIVE:    nxt_rdata = ch2_live;                // [RULE_17]
            DLSR_OFS_HS_LIVE:     nxt_rdata = hs_live;                 // [RULE_17]
            DLSR_OFS_THR_LIVE:    nxt_rdata = thr_live;                // [RULE_17]
            DLSR_OFS_HIGH_THR:    nxt_rdata = high_thr_ff;
            DLSR_OFS_LOW_THR:     nxt_rdata = low_thr_ff;
            DLSR_OFS_DIAG_EN: begin
                nxt_rdata = 8'h00;
                nxt_rdata[DLSR_BIT_SUPPLY_EN] = supply_en_ff;
                nxt_rdata[DLSR_BIT_AUX_EN]    = aux_en_ff;
            end
            DLSR_OFS_FILT_CFG: begin
                nxt_rdata = DLSR_FILT_CFG_FIXED;
                nxt_rdata[DLSR_BIT_FILT_HI:DLSR_BIT_FILT_LO] = filt_ff;
            end
            default:              nxt_rdata = DLSR_RD_UNMAPPED;
        endcase
    end

    // Read answer
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req_i.rd;
            if (req_i.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign rdata_o                        = rdata_ff;
    assign rvalid_o                       = rvalid_ff;
    assign supply_diag_enable_o           = supply_en_ff;              // [RULE_11]
    assign aux_input_diag_enable_o        = aux_en_ff;                 // [RULE_12]
    assign supply_monitor_filter_select_o = filt_ff;

endmodule : dlsr_regs
`default_nettype wire

// ---- sim/dlsr_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlsr_regs_monitor #(parameter int MEAS_W = 12) (
    // Clock and reset
    input wire logic                 mclk_i,
    input wire logic                 rst_b_i,
    // Watched ports
    input wire dlsr_pkg::dlsr_req_t  req_i,
    input wire logic [7:0]           rdata_o,
    input wire logic                 rvalid_o,
    input wire dlsr_pkg::dlsr_live_t live_i,
    input wire logic [MEAS_W-1:0]    aux_meas_i,
    input wire logic                 aux_meas_valid_i,
    input wire logic                 supply_diag_enable_o,
    input wire logic                 aux_input_diag_enable_o,
    input wire dlsr_pkg::dlsr_filt_t supply_monitor_filter_select_o
);
    import dlsr_pkg::*;
    dlsr_live_t l1_ff, l2_ff;
    always_ff @(posedge mclk_i) {l2_ff, l1_ff} <= {l1_ff, live_i};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd(logic [7:0] a);
        req_i.rd && req_i.addr == a;
    endsequence
    a_read_answer:
        assert property (req_i.rd |=> rvalid_o) else $error("read unanswered");
    a_ch2_live:
        assert property (s_rd(8'h41) |=> rdata_o == {l2_ff[9:6], 3'h0, l2_ff[5]})
        else $error("ch2 read wrong");
    a_hs_live:
        assert property (s_rd(8'h42) |=> rdata_o == {4'h0, l2_ff[4:2], 1'b0})
        else $error("headset read wrong");
    a_vad_live:
        assert property (s_rd(8'h43) |=> rdata_o[5:0] == {l2_ff[1:0], 4'h0})
        else $error("activity read wrong");
    a_aux_off:
        assert property (!aux_input_diag_enable_o [*3] ##0 s_rd(8'h43) |=> rdata_o[7:6] == 2'h0)
        else $error("flag while disabled");
    a_enable_write:
        assert property (req_i.wr && req_i.addr == 8'h53 |=> {supply_diag_enable_o,
            aux_input_diag_enable_o} == $past(req_i.wdata[2:1])) else $error("enable write lost");
    a_filter_write:
        assert property (req_i.wr && req_i.addr == 8'h54 |=>
            supply_monitor_filter_select_o == $past(req_i.wdata[6:5])) else $error("filter lost");
    a_cfg_hold:
        assert property (!req_i.wr |=> $stable({supply_diag_enable_o, aux_input_diag_enable_o,
            supply_monitor_filter_select_o})) else $error("config changed unasked");
endmodule : dlsr_regs_monitor
bind dlsr_regs dlsr_regs_monitor #(.MEAS_W(MEAS_W)) mon_u (.mclk_i, .rst_b_i, .req_i, .rdata_o,
    .rvalid_o, .live_i, .aux_meas_i, .aux_meas_valid_i, .supply_diag_enable_o,
    .aux_input_diag_enable_o, .supply_monitor_filter_select_o);
`default_nettype wire

// ---- sim/dlsr_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlsr_regs_tb;
    import dlsr_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        vld = 1'b0;
    logic        rvalid, sup_en, aux_en;
    logic [7:0]  rdata;
    logic [11:0] meas = 12'h000;
    dlsr_req_t   req = '0;
    dlsr_live_t  live = '0;
    dlsr_filt_t  filt;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          n_tests = 0;
    int          seed = 32'had097c49;
    logic [16:0] ops[18] = '{17'h0_4100, 17'h0_4200, 17'h0_4300, 17'h0_4400,
        17'h0_4EBA, 17'h0_4F4B, 17'h0_5300, 17'h0_5448,
        17'h1_4E5A, 17'h1_4FA5, 17'h1_41FF, 17'h1_43F0,
        17'h0_4E5A, 17'h0_4FA5, 17'h0_4100, 17'h0_4300,
        17'h1_4EBA, 17'h1_4F4B};
    logic [19:0] thr[6] = '{20'hF_FF80, 20'hB_A180, 20'hB_A000,
        20'h4_B000, 20'h4_AF40, 20'h0_0040};
    initial forever #2.5 mclk_i = ~mclk_i;
    dlsr_regs #(.MEAS_W(12)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .live_i(live), .aux_meas_i(meas),
        .aux_meas_valid_i(vld), .supply_diag_enable_o(sup_en),
        .aux_input_diag_enable_o(aux_en), .supply_monitor_filter_select_o(filt));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got, exp);
    endtask : check
    // One bus access; a read notes its expected answer
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req <= '{w, !w, a, d};
        if (!w) exp_q.push_back(d);
        @(posedge mclk_i);
        req <= '0;
    endtask : acc
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    always @(posedge mclk_i)
        if (rvalid === 1'b1) check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(negedge mclk_i);
        check({4'h0, sup_en, aux_en, filt}, 8'h02);
        foreach (ops[i]) acc(ops[i][16], ops[i][15:8], ops[i][7:0]);
        $display("register test done");
        for (int f = 0; f < 4; f++) begin
            acc(1'b1, 8'h54, {1'b0, 2'(f), 5'h08});
            acc(1'b1, 8'h53, {5'h00, 2'(f), 1'b0});
            @(negedge mclk_i);
            check({4'h0, sup_en, aux_en, filt}, {4'h0, 2'(f), 2'(f)});
            acc(1'b0, 8'h54, {1'b0, 2'(f), 5'h08});
        end
        $display("configuration test done");
        live <= 10'h010;
        repeat (3) @(posedge mclk_i);
        live <= '0;
        repeat (3) @(posedge mclk_i);
        acc(1'b0, 8'h3A, 8'h08);
        acc(1'b0, 8'h3A, 8'h00);
        $display("latch test done");
        vld <= 1'b1;
        foreach (thr[i]) begin
            meas <= thr[i][19:8];
            repeat (4) @(posedge mclk_i);
            acc(1'b0, 8'h43, thr[i][7:0]);
        end
        acc(1'b1, 8'h53, 8'h00);
        $display("threshold test done");
        for (int i = 0; i < 20; i++) begin
            live <= 10'($random(seed));
            repeat (3) @(posedge mclk_i);
            acc(1'b0, 8'h41, {live[9:6], 3'h0, live[5]});
            acc(1'b0, 8'h42, {4'h0, live[4:2], 1'b0});
            acc(1'b0, 8'h43, {2'h0, live[1:0], 4'h0});
        end
        $display("live test done");
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk_i);
        if (exp_q.size() > 0) check(8'h00, 8'hxx);
        conclude();
    end
endmodule : dlsr_regs_tb
`default_nettype wire
